// ===== design/amgt_pkg.sv
// Package: register map, field layout and timing for alarm mask and gate timing
`default_nettype none
package amgt_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register byte addresses
    localparam logic [4:0] ADDR_ALARM_MASK = 5'h00;
    localparam logic [4:0] ADDR_GATE_ONE   = 5'h04;
    localparam logic [4:0] ADDR_GATE_TWO   = 5'h08;
    localparam logic [4:0] ADDR_IRQ_STAT   = 5'h0C;
    localparam logic [4:0] ADDR_IRQ_MASK   = 5'h10;
    localparam logic [4:0] ADDR_ALARM_RAW  = 5'h14;
    localparam logic [4:0] ADDR_CTRL       = 5'h18;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    ////////////////////////////////////////////////////////////////////////
    // Reset values and field positions
    localparam logic [7:0]  ALARM_MASK_RST = 8'h00;
    localparam logic [15:0] GATE_ONE_RST   = 16'h0000;
    localparam logic [7:0]  GATE_TWO_RST   = 8'h00;
    localparam logic [1:0]  FREQ_RST       = 2'h1;
    localparam logic [7:0]  ALARM_USED     = 8'hDF;  // Bit 5 has no alarm
    localparam int TCC_LSB    = 0;
    localparam int GATE_DRIVE_CURRENT_LSB  = 5;
    localparam int BOOST_LSB  = 8;
    localparam int CLKMON_BIT = 11;
    localparam int DEAD_LSB   = 0;
    localparam int BLANK_LSB  = 5;
    localparam int IRQ_CLKFAIL = 0;
    localparam int IRQ_FAULT   = 1;
    localparam int IRQ_DONE    = 2;
    localparam logic [4:0] TCC_MAX_CODE = 5'h1D;
    // System clock select: 8, 16, 24, 32 MHz
    localparam logic [1:0] FREQ_8  = 2'h0;
    localparam logic [1:0] FREQ_24 = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    // Times in tenths of ns
    localparam int CLK_PERIOD_NS10     = 100;
    localparam int STEP_NS10           = 1250;
    localparam int CLKMON_TIMEOUT_NS10 = 10000;

    typedef enum logic [4:0] {
        S_IDLE  = 5'h01,
        S_BOOST = 5'h02,
        S_OFFCC = 5'h04,
        S_DEAD  = 5'h08,
        S_ONCC  = 5'h10
    } amgt_state_t;

    // Least time rounds up, never below one cycle
    function automatic logic [8:0] cyc_of_ns10(input int ns10);
        int c;
        c = (ns10 + CLK_PERIOD_NS10 - 1) / CLK_PERIOD_NS10;
        if (c < 1) begin
            c = 1;
        end
        return 9'(c);
    endfunction

    function automatic logic [8:0] step_cycles(input logic [4:0] code);
        return cyc_of_ns10((int'(code) + 1) * STEP_NS10);
    endfunction

    function automatic int boost_ns10(input logic [2:0] code, input logic [1:0] freq);
        case (code)
            3'h1:    return (freq == FREQ_8) ? 1250 : (freq == FREQ_24) ? 833 : 625;
            3'h2:    return 1250;
            3'h3:    return 2500;
            3'h4:    return 3750;
            3'h5:    return 5000;
            3'h6:    return 7500;
            3'h7:    return 10000;
            default: return 0;
        endcase
    endfunction

    function automatic logic [6:0] gate_drive_current_ma(input logic [2:0] code);
        case (code)
            3'h2:    return 7'h08;
            3'h3:    return 7'h10;
            3'h4:    return 7'h18;
            3'h5:    return 7'h20;
            3'h6:    return 7'h40;
            3'h7:    return 7'h60;
            default: return 7'h04;
        endcase
    endfunction

    localparam logic [8:0] CLKMON_CYC = cyc_of_ns10(CLKMON_TIMEOUT_NS10);

endpackage
`default_nettype wire

// ===== design/amgt_timer.sv
// One-shot cycle timer for gate phases and sense blanking
`default_nettype none
module amgt_timer
    import amgt_pkg::*;
(
    input  wire logic       aclk,    // System clock
    input  wire logic       aresetn, // Sync reset, active low
    input  wire logic       start,   // Load and run
    input  wire logic [8:0] cycles,  // Run length in cycles
    output logic            busy,    // High for the run length
    output logic            done     // High in the last run cycle
);
    typedef struct packed {
        logic [8:0] cnt;
        logic       busy;
    } amgt_tmr_t;

    amgt_tmr_t st_r;
    amgt_tmr_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (start) begin
            st_nxt.cnt  = cycles;
            st_nxt.busy = (cycles != 9'h000);
        end else if (st_r.cnt != 9'h000) begin
            st_nxt.cnt  = st_r.cnt - 9'h001;
            st_nxt.busy = (st_r.cnt > 9'h001);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign busy = st_r.busy;
    assign done = st_r.busy && (st_r.cnt == 9'h001);

endmodule
`default_nettype wire

// ===== design/amgt_clkmon.sv
// Clock source monitor: flags a missing source tick
`default_nettype none
module amgt_clkmon
    import amgt_pkg::*;
(
    input  wire logic aclk,     // System clock
    input  wire logic aresetn,  // Sync reset, active low
    input  wire logic enable,   // Monitoring on
    input  wire logic osc_tick, // One pulse per source clock edge
    output logic      fail      // One-cycle pulse on loss
);
    typedef struct packed {
        logic [8:0] cnt;
        logic       tripped;
        logic       fail;
    } amgt_mon_t;

    amgt_mon_t st_r;
    amgt_mon_t st_nxt;

    always_comb begin
        st_nxt      = st_r;
        st_nxt.fail = 1'h0;
        if (!enable || osc_tick) begin
            st_nxt.cnt     = 9'h000;
            st_nxt.tripped = 1'h0;
        end else if (!st_r.tripped) begin
            if (st_r.cnt == CLKMON_CYC - 9'h001) begin
                st_nxt.tripped = 1'h1;
                st_nxt.fail    = 1'h1;
            end else begin
                st_nxt.cnt = st_r.cnt + 9'h001;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign fail = st_r.fail;

    a_mon_gated: assert property (@(posedge aclk) disable iff (!aresetn)
        !enable |=> !fail) else $error("clock monitor fired while disabled");

endmodule
`default_nettype wire

// ===== design/amgt_top.sv
// Alarm mask, gate timing sequencer and register slave
//
// Design decisions made here: the AXI4-Lite register port and the address map.
`default_nettype none
module amgt_top
    import amgt_pkg::*;
(
    input  wire logic        aclk,            // 100 MHz clock
    input  wire logic        aresetn,         // Sync reset, active low
    input  wire logic        awvalid,         // Write address valid
    output logic             awready,         // Write address ready
    input  wire logic [4:0]  awaddr,          // Write byte address
    input  wire logic        wvalid,          // Write data valid
    output logic             wready,          // Write data ready
    input  wire logic [31:0] wdata,           // Write data
    input  wire logic [3:0]  wstrb,           // Write byte lanes
    output logic             bvalid,          // Write response valid
    input  wire logic        bready,          // Write response ready
    output logic [1:0]       bresp,           // Write response
    input  wire logic        arvalid,         // Read address valid
    output logic             arready,         // Read address ready
    input  wire logic [4:0]  araddr,          // Read byte address
    output logic             rvalid,          // Read data valid
    input  wire logic        rready,          // Read data ready
    output logic [31:0]      rdata,           // Read data
    output logic [1:0]       rresp,           // Read response
    input  wire logic [7:0]  alarm_in,        // Alarm condition levels
    input  wire logic        osc_tick,        // Clock source tick
    input  wire logic        commutate,       // Commutation request pulse
    output logic             fault_level,     // Fault pin level when driven
    output logic             fault_oe,        // Fault pin pulled low
    output logic [6:0]       gate_current_ma, // Gate current in mA
    output logic             boost_on,        // Turn-off boost phase
    output logic             off_cc_on,       // Turn-off constant current
    output logic             dead_on,         // Dead time
    output logic             on_cc_on,        // Turn-on constant current
    output logic             sense_blank,     // Comparators blanked
    output logic             irq              // Interrupt, active high
);

    ////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        arready;
        logic        aw_got;
        logic [4:0]  aw_addr;
        logic        w_got;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [7:0]  alarm_mask;
        logic [15:0] gate_one;
        logic [7:0]  gate_two;
        logic [1:0]  freq;
        logic [2:0]  irq_stat;
        logic [2:0]  irq_mask;
        logic        irq;
        logic        fault_o;
        logic        fault_oe;
        logic [6:0]  gate_ma;
        amgt_state_t state;
    } amgt_top_t;

    amgt_top_t st_r;
    amgt_top_t st_nxt;

    logic       t_start;
    logic [8:0] t_cyc;
    logic       t_done;
    logic       b_start;
    logic       clk_fail;
    logic       seq_done;
    logic       wr_go;
    logic       fault_now;
    logic [2:0] clr;
    logic [2:0] ev;
    logic [31:0] wv;
    logic [8:0] tcc_cyc;
    logic [8:0] boost_cyc;
    logic [8:0] dead_cyc;
    logic [8:0] blank_cyc;
    logic [2:0] boost_code;

    function automatic logic is_mapped(input logic [4:0] a);
        return (a <= ADDR_CTRL) && (a[1:0] == 2'h0);
    endfunction

    function automatic logic [31:0] rd_word(input logic [4:0] a);
        case (a)
            ADDR_ALARM_MASK: return {24'h000000, st_r.alarm_mask};
            ADDR_GATE_ONE:   return {16'h0000, st_r.gate_one};
            ADDR_GATE_TWO:   return {24'h000000, st_r.gate_two};
            ADDR_IRQ_STAT:   return {29'h00000000, st_r.irq_stat};
            ADDR_IRQ_MASK:   return {29'h00000000, st_r.irq_mask};
            ADDR_ALARM_RAW:  return {23'h000000, st_r.fault_oe, alarm_in};
            ADDR_CTRL:       return {30'h00000000, st_r.freq};
            default:         return 32'h00000000;
        endcase
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[8*i +: 8] = d[8*i +: 8];
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Phase lengths from live configuration

    assign boost_code = st_r.gate_one[BOOST_LSB +: 3];
    assign boost_cyc  = cyc_of_ns10(boost_ns10(boost_code, st_r.freq));
    assign dead_cyc   = step_cycles(st_r.gate_two[DEAD_LSB +: 5]);
    assign blank_cyc  = step_cycles({2'h0, st_r.gate_two[BLANK_LSB +: 3]});
    assign tcc_cyc    = (st_r.gate_one[TCC_LSB +: 5] > TCC_MAX_CODE) ?
                        step_cycles(TCC_MAX_CODE) : step_cycles(st_r.gate_one[TCC_LSB +: 5]);

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        st_nxt = st_r;
        clr    = 3'h0;
        wv     = 32'h00000000;
        st_nxt.bvalid = st_r.bvalid && !bready;
        st_nxt.rvalid = st_r.rvalid && !rready;
        if (awvalid && st_r.awready) begin
            st_nxt.aw_got  = 1'h1;
            st_nxt.aw_addr = awaddr;
        end
        if (wvalid && st_r.wready) begin
            st_nxt.w_got = 1'h1;
            st_nxt.wdata = wdata;
            st_nxt.wstrb = wstrb;
        end
        wr_go = st_nxt.aw_got && st_nxt.w_got && !st_nxt.bvalid;
        if (wr_go) begin
            st_nxt.aw_got = 1'h0;
            st_nxt.w_got  = 1'h0;
            st_nxt.bvalid = 1'h1;
            st_nxt.bresp  = RESP_OKAY;
            wv = merge(rd_word(st_nxt.aw_addr), st_nxt.wdata, st_nxt.wstrb);
            case (st_nxt.aw_addr)
                ADDR_ALARM_MASK: st_nxt.alarm_mask = wv[7:0];
                ADDR_GATE_ONE:   st_nxt.gate_one = wv[15:0];
                ADDR_GATE_TWO:   st_nxt.gate_two = wv[7:0];
                ADDR_IRQ_STAT:   clr = st_nxt.wdata[2:0] & {3{st_nxt.wstrb[0]}};
                ADDR_IRQ_MASK:   st_nxt.irq_mask = wv[2:0];
                ADDR_CTRL:       st_nxt.freq = wv[1:0];
                ADDR_ALARM_RAW:  st_nxt.bresp = RESP_OKAY;
                default:         st_nxt.bresp = RESP_DECERR;
            endcase
        end
        if (arvalid && st_r.arready) begin
            st_nxt.rvalid = 1'h1;
            st_nxt.rdata  = rd_word(araddr);
            st_nxt.rresp  = is_mapped(araddr) ? RESP_OKAY : RESP_DECERR;
        end
        st_nxt.awready = !st_nxt.aw_got && !st_nxt.bvalid;
        st_nxt.wready  = !st_nxt.w_got && !st_nxt.bvalid;
        st_nxt.arready = !st_nxt.rvalid;

        // Fault pin follows the mask every cycle
        fault_now       = |(alarm_in & st_r.alarm_mask & ALARM_USED);
        st_nxt.fault_oe = fault_now;
        st_nxt.fault_o  = 1'h0;
        st_nxt.gate_ma  = gate_drive_current_ma(st_r.gate_one[GATE_DRIVE_CURRENT_LSB +: 3]);

        // Gate sequence: boost, off cc, dead, on cc
        t_start  = 1'h0;
        t_cyc    = 9'h000;
        b_start  = 1'h0;
        seq_done = 1'h0;
        case (st_r.state)
            S_IDLE: begin
                if (commutate) begin
                    t_start = 1'h1;
                    if (boost_code != 3'h0) begin
                        st_nxt.state = S_BOOST;
                        t_cyc        = boost_cyc;
                    end else begin
                        st_nxt.state = S_OFFCC;
                        t_cyc        = tcc_cyc;
                    end
                end
            end
            S_BOOST: begin
                if (t_done) begin
                    t_start      = 1'h1;
                    t_cyc        = tcc_cyc;
                    st_nxt.state = S_OFFCC;
                end
            end
            S_OFFCC: begin
                if (t_done) begin
                    t_start      = 1'h1;
                    t_cyc        = dead_cyc;
                    st_nxt.state = S_DEAD;
                end
            end
            S_DEAD: begin
                if (t_done) begin
                    t_start      = 1'h1;
                    t_cyc        = tcc_cyc;
                    b_start      = 1'h1;
                    st_nxt.state = S_ONCC;
                end
            end
            S_ONCC: begin
                if (t_done) begin
                    st_nxt.state = S_IDLE;
                    seq_done     = 1'h1;
                end
            end
            default: st_nxt.state = S_IDLE;
        endcase

        // Sticky events, set beats clear
        ev              = 3'h0;
        ev[IRQ_CLKFAIL] = clk_fail;
        ev[IRQ_FAULT]   = fault_now && !st_r.fault_oe;
        ev[IRQ_DONE]    = seq_done;
        st_nxt.irq_stat = (st_r.irq_stat & ~clr) | ev;
        st_nxt.irq      = |(st_nxt.irq_stat & st_nxt.irq_mask);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r            <= '0;
            st_r.alarm_mask <= ALARM_MASK_RST;
            st_r.gate_one   <= GATE_ONE_RST;
            st_r.gate_two   <= GATE_TWO_RST;
            st_r.freq       <= FREQ_RST;
            st_r.gate_ma    <= gate_drive_current_ma(3'h0);
            st_r.state      <= S_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Submodules

    amgt_timer u_phase (
        .aclk    (aclk),
        .aresetn (aresetn),
        .start   (t_start),
        .cycles  (t_cyc),
        .busy    (),
        .done    (t_done)
    );

    amgt_timer u_blank (
        .aclk    (aclk),
        .aresetn (aresetn),
        .start   (b_start),
        .cycles  (blank_cyc),
        .busy    (sense_blank),
        .done    ()
    );

    amgt_clkmon u_clkmon (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .enable   (st_r.gate_one[CLKMON_BIT]),
        .osc_tick (osc_tick),
        .fail     (clk_fail)
    );

    assign awready         = st_r.awready;
    assign wready          = st_r.wready;
    assign arready         = st_r.arready;
    assign bvalid          = st_r.bvalid;
    assign bresp           = st_r.bresp;
    assign rvalid          = st_r.rvalid;
    assign rdata           = st_r.rdata;
    assign rresp           = st_r.rresp;
    assign fault_level     = st_r.fault_o;
    assign fault_oe        = st_r.fault_oe;
    assign gate_current_ma = st_r.gate_ma;
    assign boost_on        = st_r.state[1];
    assign off_cc_on       = st_r.state[2];
    assign dead_on         = st_r.state[3];
    assign on_cc_on        = st_r.state[4];
    assign irq             = st_r.irq;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    logic [9:0] ph_len_r;
    logic [9:0] blank_len_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ph_len_r    <= 10'h000;
            blank_len_r <= 10'h000;
        end else begin
            ph_len_r    <= (st_nxt.state != st_r.state) ? 10'h000 : ph_len_r + 10'h001;
            blank_len_r <= sense_blank ? blank_len_r + 10'h001 : 10'h000;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_fault_raise: assert property (
        (|(alarm_in & st_r.alarm_mask & ALARM_USED)) |=> fault_oe)
        else $error("masked alarm did not pull fault low");
    a_fault_release: assert property (
        !(|(alarm_in & st_r.alarm_mask & ALARM_USED)) |=> !fault_oe && !fault_level)
        else $error("fault held without masked alarm");
    a_unused_bit: assert property (
        (alarm_in == 8'h20) |=> !fault_oe)
        else $error("unused alarm bit drove fault");
    a_gate_current: assert property (
        ##1 gate_current_ma == gate_drive_current_ma($past(st_r.gate_one[GATE_DRIVE_CURRENT_LSB +: 3])))
        else $error("gate current code mismatch");
    a_tcc_len: assert property (
        ($past(st_r.state) == S_OFFCC && st_r.state != S_OFFCC) |->
        $past(ph_len_r) + 10'h001 == {1'h0, $past(tcc_cyc)})
        else $error("constant current phase length wrong");
    a_boost_skip: assert property (
        (st_r.state == S_IDLE && commutate && boost_code == 3'h0) |=> off_cc_on && !boost_on)
        else $error("disabled boost still ran");
    a_boost_len: assert property (
        ($past(st_r.state) == S_BOOST && st_r.state != S_BOOST) |->
        $past(ph_len_r) + 10'h001 == {1'h0, $past(boost_cyc)})
        else $error("boost phase length wrong");
    a_dead_len: assert property (
        $fell(dead_on) |-> $past(ph_len_r) + 10'h001 == {1'h0, $past(dead_cyc)} && on_cc_on)
        else $error("dead time length wrong");
    a_blank_start: assert property (
        ($past(st_r.state) == S_DEAD && on_cc_on) |-> sense_blank)
        else $error("blanking did not start on commutation");
    a_blank_len: assert property (
        $fell(sense_blank) |-> blank_len_r == {1'h0, $past(blank_cyc)})
        else $error("blanking length wrong");

    c_boost_seq: cover property (boost_on ##[1:300] on_cc_on);
    c_fault: cover property ($rose(fault_oe));
    c_clk_fail: cover property (clk_fail);
    c_decerr: cover property (rvalid && rresp == RESP_DECERR);

endmodule
`default_nettype wire

// ===== sim/amgt_far.sv
// Far-side model: fault pin pull-up and clock source ticks
`default_nettype none
module amgt_far (
    input  wire logic aclk,        // System clock
    input  wire logic tick_run,    // Clock source running
    input  wire logic fault_level, // Pin level when driven
    input  wire logic fault_oe,    // Pin driven low
    output logic      osc_tick,    // Clock source tick
    output logic      fault_pin    // Resolved pin level
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] div = 2'h0;
    always @(posedge aclk) div <= div + 2'h1;
    assign osc_tick  = tick_run && (div == 2'h0);
    // Pull-up holds the pin high when released
    assign fault_pin = fault_oe ? fault_level : 1'b1;
endmodule
`default_nettype wire

// ===== sim/alarm_mask_and_gate_timing_bench.sv
// Bench: register, fault, gate timing and clock monitor tests
`default_nettype none
module alarm_mask_and_gate_timing_bench
    import amgt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [4:0]  awaddr = 5'h00, araddr = 5'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'hF;
    logic [7:0]  alarm_in = 8'h00;
    logic        commutate = 1'b0, tick_run = 1'b1, cnt_en = 1'b0;
    wire         awready, wready, bvalid, arready, rvalid, fault_level, fault_oe, irq, osc_tick, fault_pin;
    wire         boost_on, off_cc_on, dead_on, on_cc_on, sense_blank;
    wire [1:0]   bresp, rresp;
    wire [31:0]  rdata;
    wire [6:0]   gate_current_ma;
    int          err_total = 0, checks = 0, cyc = 0;
    integer      nb, nt, nd, nk, no;
    int          ma[8] = '{4, 4, 8, 16, 24, 32, 64, 96};
    int          bt[7] = '{0, 0, 13, 25, 38, 50, 75};
    logic [31:0] rd;
    logic [1:0]  rs;

    amgt_top DUT (.*);
    amgt_far far (.*);

    ////////////////////////////////////////////////////////////////////////
    always #5 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_total++;
            final_report();
        end
        if (cnt_en) begin
            nb += boost_on;
            nt += off_cc_on;
            nd += dead_on;
            no += on_cc_on;
            nk += sense_blank;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge aclk);
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        awaddr <= a;
        wdata <= d;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        rs = bresp;
    endtask
    task automatic rdr(input logic [4:0] a);
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        rd = rdata;
        rs = rresp;
    endtask
    // One commutation, phase lengths counted in cycles
    task automatic run(input logic [31:0] g1, g2, input logic [1:0] f, input int b, t, d, k);
        wr(ADDR_GATE_ONE, g1);
        wr(ADDR_GATE_TWO, g2);
        wr(ADDR_CTRL, {30'h0, f});
        nb = 0;
        nt = 0;
        nd = 0;
        nk = 0;
        no = 0;
        @(posedge aclk);
        commutate <= 1'b1;
        cnt_en <= 1'b1;
        @(posedge aclk);
        commutate <= 1'b0;
        while (!on_cc_on) @(posedge aclk);
        while (on_cc_on) @(posedge aclk);
        idle(3);
        cnt_en <= 1'b0;
        chk("boost", b, nb);
        chk("off_cc", t, nt);
        chk("dead", d, nd);
        chk("on_cc", t, no);
        chk("blank", k, nk);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        idle(12);
        aresetn <= 1'b1;
        rdr(ADDR_ALARM_MASK);
        chk("mask reset", ALARM_MASK_RST, rd);
        rdr(ADDR_GATE_ONE);
        chk("gate one reset", GATE_ONE_RST, rd);
        rdr(ADDR_GATE_TWO);
        chk("gate two reset", GATE_TWO_RST, rd);
        rdr(5'h1C);
        chk("unmapped read", RESP_DECERR, rs);
        wr(5'h02, 32'hFF);
        chk("unaligned write", RESP_DECERR, rs);
        $display("test registers done");
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_ALARM_MASK, 32'h1 << i);
            alarm_in <= 8'h1 << i;
            idle(3);
            chk("fault pin", (i == 5) ? 1'b1 : 1'b0, fault_pin);
            rdr(ADDR_ALARM_RAW);
            chk("alarm raw", {23'h000000, i != 5, 8'h1 << i}, rd);
            alarm_in <= ~(8'h1 << i);
            idle(3);
            chk("fault release", 1'b1, fault_pin);
        end
        alarm_in <= 8'h00;
        for (int c = 0; c < 8; c++) begin
            wr(ADDR_GATE_ONE, c << GATE_DRIVE_CURRENT_LSB);
            idle(2);
            chk("gate current", ma[c], gate_current_ma);
        end
        $display("test fault and current done");
        wr(ADDR_IRQ_MASK, 32'h4);
        wr(ADDR_IRQ_STAT, 32'h7);
        run(32'h071F, 32'hFF, 2'h1, 100, 375, 400, 100);
        chk("irq done", 1'b1, irq);
        wr(ADDR_IRQ_STAT, 32'h4);
        idle(2);
        chk("irq clear", 1'b0, irq);
        run(32'h0100, 32'h00, 2'h0, 13, 13, 13, 13);
        run(32'h0100, 32'h05, 2'h2, 9, 13, 75, 13);
        run(32'h001E, 32'h00, 2'h3, 0, 375, 13, 13);
        run(32'h0101, 32'h20, 2'h3, 7, 25, 13, 25);
        for (int c = 2; c < 7; c++) run(c << BOOST_LSB, 32'h0, 2'h1, bt[c], 13, 13, 13);
        chk("irq again", 1'b1, irq);
        wr(ADDR_IRQ_MASK, 32'h0);
        idle(2);
        chk("irq masked", 1'b0, irq);
        $display("test sequences done");
        wr(ADDR_IRQ_STAT, 32'h7);
        wr(ADDR_GATE_ONE, 32'h1 << CLKMON_BIT);
        idle(300);
        rdr(ADDR_IRQ_STAT);
        chk("clock present", 1'b0, rd[IRQ_CLKFAIL]);
        tick_run <= 1'b0;
        idle(150);
        rdr(ADDR_IRQ_STAT);
        chk("clock lost", 1'b1, rd[IRQ_CLKFAIL]);
        wr(ADDR_GATE_ONE, 32'h0);
        wr(ADDR_IRQ_STAT, 32'h7);
        idle(200);
        rdr(ADDR_IRQ_STAT);
        chk("monitor off", 1'b0, rd[IRQ_CLKFAIL]);
        $display("test clock monitor done");
        final_report();
    end
endmodule
`default_nettype wire
